// ===== verilog/iemd_exec_unit.sv
// Integer execute stage with bypassed register file and product/quotient unit.
// Assumes the issuer waits while stall is high and loads return data in the same
// cycle as the request.
// How it works
// RL1 - Thirty-two 32-bit registers, two reads, one write
// RL2 - Bypass recent results to consumers without stalling; a consumer of a two-pass or deferred register multiply stalls instead
// RL3 - ALU ops single cycle; memory via aligners
// RL4 - Address adder, next address, branch resolution
// RL5 - Count leading zeros or leading ones
// RL6 - Product/quotient pipeline runs despite integer stalls
// RL7 - Booth 32x16 array; wide source_b needs two passes
// RL8 - No back-to-back 32x32 multiply; interlock stalls issue
// RL9 - Multiply latency and repeat per width, destination
// RL10 - Divide resolves one quotient bit per cycle
// RL11 - Skip 23, 15, 7 iterations by dividend width
// RL12 - Divide latency 12, 19, 26, 33 cycles
// RL13 - Further product/quotient op waits for divide; a register multiply may still issue in the divide's last cycle
// RL14 - Results into pair; moves copy halves out
// RL15 - Register-destination multiply writes low word
// RL16 - Accumulate adds, deduct subtracts, 64-bit pair
// RL17 - Quotient in bottom word, remainder upper
// RL18 - Register zero reads zero, ignores writes
`timescale 1ns/1ns
module iemd_exec_unit (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire iemd_pkg::iemd_issue_t issue,
  input  wire iemd_pkg::iemd_word_t  load_data,
  output logic                      stall,
  output iemd_pkg::iemd_mem_req_t   mem_req,
  output iemd_pkg::iemd_flow_t      flow,
  output iemd_pkg::iemd_wb_t        wb,
  output logic                      pq_busy
);
  import iemd_pkg::*;

  function automatic logic is_mul(input iemd_op_t op);
    return op inside {OP_PRODUCT_TO_PAIR, OP_PRODUCT_ACCUMULATE, OP_PRODUCT_DEDUCT,
                      OP_PRODUCT_TO_REG};
  endfunction

  function automatic logic is_pq(input iemd_op_t op);
    return is_mul(op) || op inside {OP_QUOTIENT, OP_MOVE_FROM_UPPER, OP_MOVE_FROM_BOTTOM};
  endfunction

  // Ops writing a register at the end of their execute cycle
  function automatic logic writes_reg(input iemd_op_t op);
    return op inside {[OP_ADD:OP_COUNT_LEADING_ONES], OP_MOVE_FROM_UPPER, OP_MOVE_FROM_BOTTOM};
  endfunction

  function automatic logic hits(input iemd_issue_t i, input iemd_ridx_t r);
    return (r != ZERO_REG) && (i.source_a == r || i.source_b == r);
  endfunction

  function automatic logic [5:0] lead_ones(input iemd_word_t v);
    logic [5:0] n;
    logic       run;
    n   = 6'h00;
    run = 1'b1;
    for (int i = 31; i >= 0; i--) begin
      if (run && v[i]) n = n + 6'h01;
      else run = 1'b0;
    end
    return n;
  endfunction

  // Radix-4 recoded 33x17 signed array, one pass
  function automatic logic signed [49:0] booth_mul(input logic [32:0] m, input logic [16:0] r);
    logic [18:0]        rx;
    logic signed [49:0] mx;
    logic signed [49:0] acc;
    rx  = {r[16], r, 1'b0};
    mx  = {{17{m[32]}}, m};
    acc = '0;
    for (int i = 0; i < 9; i++) begin
      case (rx[2*i +: 3])
        3'b001, 3'b010: acc = acc + (mx <<< (2*i));
        3'b011:         acc = acc + (mx <<< (2*i + 1));
        3'b100:         acc = acc - (mx <<< (2*i + 1));
        3'b101, 3'b110: acc = acc - (mx <<< (2*i));
        default:        acc = acc;
      endcase
    end
    return acc;
  endfunction

  function automatic logic [5:0] div_skip(input iemd_word_t a, input logic uns);
    if (uns ? (a[31:8] == '0) : (&a[31:7] || ~|a[31:7])) return SKIP_8;
    else if (uns ? (a[31:16] == '0) : (&a[31:15] || ~|a[31:15])) return SKIP_16;
    else if (uns ? (a[31:24] == '0) : (&a[31:23] || ~|a[31:23])) return SKIP_24;
    else return SKIP_32;
  endfunction

  function automatic iemd_word_t magn(input iemd_word_t v, input logic uns);
    return (!uns && v[31]) ? (WORD_RESET - v) : v;
  endfunction

  iemd_issue_t ex;
  iemd_word_t  rd_a, rd_b, opa, regb, opb, alu_res, data_addr, load_aligned, load_shift;
  iemd_word_t  result_upper_word, result_bottom_word;
  logic        ex_go, pq_go, wr_en, late_now;
  iemd_ridx_t  wr_idx;
  iemd_word_t  wr_data;

  struct packed { logic valid; iemd_ridx_t dst; logic [1:0] off; iemd_size_t size;
                  logic uns; } load_wb;
  struct packed { logic valid; iemd_ridx_t dst; iemd_word_t data; } mul_wb;

  logic        pass2_active, p2_uns;
  iemd_op_t    p2_op;
  iemd_ridx_t  p2_dst;
  iemd_word_t  p2_a, p2_b;
  logic [63:0] p2_partial;

  logic        div_active, div_neg_q, div_neg_r;
  logic [5:0]  div_cycles, div_bits;
  iemd_word_t  div_rem, div_quo, div_den;

  assign ex_go  = ex.valid && !stall;
  assign pq_go  = ex_go && is_pq(ex.op);

  iemd_regfile u_regs (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .raddr_a  (stall ? ex.source_a : issue.source_a),
    .raddr_b  (stall ? ex.source_b : issue.source_b),
    .rdata_a  (rd_a),
    .rdata_b  (rd_b),
    .we       (wr_en),
    .waddr    (wr_idx),
    .wdata    (wr_data)
  );

  // Load aligner: pick the addressed lane, then extend
  always_comb begin
    load_shift = load_data >> {load_wb.off, 3'b000};
    case (load_wb.size)
      SIZE_BYTE: load_aligned = {{24{load_shift[7] & !load_wb.uns}}, load_shift[7:0]}; // [RL3]
      SIZE_HALF: load_aligned = {{16{load_shift[15] & !load_wb.uns}}, load_shift[15:0]};
      default:   load_aligned = load_shift;
    endcase
  end

  // Late writers (load, register multiply) win the port; stall keeps ex off it
  always_comb begin
    late_now = load_wb.valid || mul_wb.valid;
    wr_en    = 1'b1;
    if (load_wb.valid) begin
      wr_idx  = load_wb.dst;
      wr_data = load_aligned;
    end else if (mul_wb.valid) begin
      wr_idx  = mul_wb.dst;
      wr_data = mul_wb.data; // [RL15]
    end else begin
      wr_en   = ex_go && writes_reg(ex.op);
      wr_idx  = ex.dst;
      wr_data = alu_res;
    end
  end

  // Bypass: a late write this cycle, else last cycle's write, else the file
  function automatic iemd_word_t fwd(input iemd_ridx_t idx, input iemd_word_t rf);
    if (idx == ZERO_REG) return WORD_RESET; // [RL18]
    else if (late_now && wr_idx == idx) return wr_data; // [RL2]
    else if (wb.valid && wb.idx == idx) return wb.data; // [RL2]
    else return rf;
  endfunction

  assign opa       = fwd(ex.source_a, rd_a);
  assign regb      = fwd(ex.source_b, rd_b);
  assign opb       = ex.use_imm ? ex.imm : regb;
  assign data_addr = opa + ex.imm; // [RL4]

  always_comb begin
    case (ex.op)
      OP_ADD:  alu_res = opa + opb; // [RL3]
      OP_SUB:  alu_res = opa - opb;
      OP_AND:  alu_res = opa & opb;
      OP_OR:   alu_res = opa | opb;
      OP_XOR:  alu_res = opa ^ opb;
      OP_NOR:  alu_res = ~(opa | opb);
      OP_SLT:  alu_res = {31'h0000_0000, ex.unsigned_op ? (opa < opb)
                                         : ($signed(opa) < $signed(opb))};
      OP_SLL:  alu_res = opa << opb[4:0];
      OP_SRL:  alu_res = opa >> opb[4:0];
      OP_SRA:  alu_res = iemd_word_t'($signed(opa) >>> opb[4:0]);
      OP_COUNT_LEADING_ZEROS: alu_res = {26'h000_0000, lead_ones(~opa)}; // [RL5]
      OP_COUNT_LEADING_ONES:  alu_res = {26'h000_0000, lead_ones(opa)};  // [RL5]
      OP_MOVE_FROM_UPPER:     alu_res = result_upper_word;  // [RL14]
      OP_MOVE_FROM_BOTTOM:    alu_res = result_bottom_word; // [RL14]
      default: alu_res = WORD_RESET;
    endcase
  end

  // Multiplier: source_b width alone decides one pass or two
  logic        mul_fits, mul_done, take_pass2;
  logic [32:0] mul_m;
  logic [16:0] mul_r;
  logic [49:0] pp;
  logic [63:0] pp_ext, prod, pair;
  iemd_op_t    mop;
  iemd_ridx_t  mdst;

  assign mul_fits   = ex.unsigned_op ? (regb[31:16] == '0) : (&regb[31:15] || ~|regb[31:15]);
  assign mul_m      = pass2_active ? {p2_a[31] & !p2_uns, p2_a}
                                   : {opa[31] & !ex.unsigned_op, opa};
  assign mul_r      = pass2_active ? {p2_b[31] & !p2_uns, p2_b[31:16]}
                    : (mul_fits && !ex.unsigned_op) ? regb[16:0] : {1'b0, regb[15:0]}; // [RL7]
  assign pp         = booth_mul(mul_m, mul_r); // [RL7]
  assign pp_ext     = {{14{pp[49]}}, pp};
  assign prod       = pass2_active ? (p2_partial + (pp_ext << 16)) : pp_ext;
  assign take_pass2 = pq_go && is_mul(ex.op) && !mul_fits; // [RL7]
  assign mul_done   = pass2_active || (pq_go && is_mul(ex.op) && mul_fits); // [RL9]
  assign mop        = pass2_active ? p2_op : ex.op;
  assign mdst       = pass2_active ? p2_dst : ex.dst;
  assign pair       = {result_upper_word, result_bottom_word};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pass2_active <= 1'b0;
      p2_op        <= OP_NOP;
      p2_dst       <= ZERO_REG;
      p2_uns       <= 1'b0;
      p2_a         <= WORD_RESET;
      p2_b         <= WORD_RESET;
      p2_partial   <= '0;
    end else begin
      pass2_active <= take_pass2; // [RL6] [RL7]
      if (take_pass2) begin
        p2_op      <= ex.op;
        p2_dst     <= ex.dst;
        p2_uns     <= ex.unsigned_op;
        p2_a       <= opa;
        p2_b       <= regb;
        p2_partial <= pp_ext;
      end
    end
  end

  // Divider: restoring, one quotient bit per cycle after the early-in skip
  logic        div_start, div_done;
  logic [5:0]  skip_now, lat_now;
  logic [32:0] rem_sh, trial;
  iemd_word_t  step_rem, step_quo, fin_quo, fin_rem;

  assign div_start = pq_go && ex.op == OP_QUOTIENT;
  assign skip_now  = div_skip(opa, ex.unsigned_op); // [RL11]
  assign lat_now   = (skip_now == SKIP_8)  ? DIV_LAT_8  : (skip_now == SKIP_16) ? DIV_LAT_16
                   : (skip_now == SKIP_24) ? DIV_LAT_24 : DIV_LAT_32; // [RL12]
  assign div_done  = div_active && div_cycles == 6'h01;

  always_comb begin
    rem_sh   = {div_rem, div_quo[31]};
    trial    = rem_sh - {1'b0, div_den};
    step_rem = div_rem;
    step_quo = div_quo;
    if (div_bits != 6'h00) begin
      step_rem = trial[32] ? rem_sh[31:0] : trial[31:0]; // [RL10]
      step_quo = {div_quo[30:0], !trial[32]};
    end
    fin_quo = div_neg_q ? (WORD_RESET - step_quo) : step_quo;
    fin_rem = div_neg_r ? (WORD_RESET - step_rem) : step_rem;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_active <= 1'b0;
      div_cycles <= 6'h00;
      div_bits   <= 6'h00;
      div_rem    <= WORD_RESET;
      div_quo    <= WORD_RESET;
      div_den    <= WORD_RESET;
      div_neg_q  <= 1'b0;
      div_neg_r  <= 1'b0;
    end else if (div_start) begin
      div_active <= 1'b1;
      div_cycles <= lat_now - 6'h01; // [RL12]
      div_bits   <= DIV_BITS - skip_now; // [RL11]
      div_rem    <= WORD_RESET;
      div_quo    <= magn(opa, ex.unsigned_op) << skip_now;
      div_den    <= magn(regb, ex.unsigned_op);
      div_neg_q  <= !ex.unsigned_op && (opa[31] ^ regb[31]);
      div_neg_r  <= !ex.unsigned_op && opa[31];
    end else if (div_active) begin
      div_cycles <= div_cycles - 6'h01; // [RL6]
      div_active <= !div_done;
      div_rem    <= step_rem;
      div_quo    <= step_quo;
      if (div_bits != 6'h00) div_bits <= div_bits - 6'h01; // [RL10]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_upper_word  <= WORD_RESET;
      result_bottom_word <= WORD_RESET;
    end else if (div_done) begin
      result_upper_word  <= fin_rem; // [RL17]
      result_bottom_word <= fin_quo; // [RL17]
    end else if (mul_done && mop != OP_PRODUCT_TO_REG) begin
      case (mop)
        OP_PRODUCT_ACCUMULATE: {result_upper_word, result_bottom_word} <= pair + prod; // [RL16]
        OP_PRODUCT_DEDUCT:     {result_upper_word, result_bottom_word} <= pair - prod; // [RL16]
        default:               {result_upper_word, result_bottom_word} <= prod;        // [RL14]
      endcase
    end
  end

  // Late writebacks; a register multiply waits one cycle behind a load
  logic next_load_wb, next_mul_wb;
  assign next_load_wb = ex_go && ex.op == OP_LOAD;
  assign next_mul_wb  = (mul_done && mop == OP_PRODUCT_TO_REG) || (mul_wb.valid && load_wb.valid);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_wb <= '0;
      mul_wb  <= '0;
    end else begin
      load_wb <= {next_load_wb, ex.dst, data_addr[1:0], ex.size, ex.unsigned_op};
      if (mul_done && mop == OP_PRODUCT_TO_REG) mul_wb <= {1'b1, mdst, prod[31:0]}; // [RL15] [RL9]
      else if (!load_wb.valid) mul_wb <= '0;
    end
  end

  // Interlock predicted a cycle ahead so stall leaves a flip-flop
  iemd_issue_t next_ex;
  logic        next_div_active, next_div_last, next_deferred, next_stall;
  iemd_ridx_t  next_mul_dst;

  always_comb begin
    next_ex         = stall ? ex : issue;
    next_div_active = div_start || (div_active && !div_done);
    next_div_last   = div_active && div_cycles == 6'h02;
    next_deferred   = next_mul_wb && next_load_wb;
    next_mul_dst    = mul_done ? mdst : mul_wb.dst;
    next_stall      = next_ex.valid && (
        (is_pq(next_ex.op) && take_pass2) || // [RL8]
        (is_pq(next_ex.op) && next_deferred) ||
        (is_pq(next_ex.op) && next_div_active &&
         !(next_div_last && next_ex.op == OP_PRODUCT_TO_REG)) || // [RL13]
        (writes_reg(next_ex.op) && (next_load_wb || next_mul_wb)) ||
        (take_pass2 && ex.op == OP_PRODUCT_TO_REG && hits(next_ex, ex.dst)) ||
        (next_deferred && hits(next_ex, next_mul_dst)));
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stall    <= 1'b0;
      pq_busy  <= 1'b0;
      ex       <= '0;
      wb       <= '0;
    end else begin
      stall    <= next_stall; // [RL8] [RL13]
      pq_busy  <= take_pass2 || next_div_active;
      ex       <= next_ex;
      wb       <= {wr_en && wr_idx != ZERO_REG, wr_idx, wr_data}; // [RL18]
    end
  end

  // Branch resolution and next-instruction address
  logic       br_cond;
  iemd_word_t seq_pc;
  assign seq_pc = ex.pc + PC_STEP;

  always_comb begin
    case (ex.op)
      OP_BEQ:      br_cond = opa == regb; // [RL4]
      OP_BNE:      br_cond = opa != regb;
      OP_BLEZ:     br_cond = opa[31] || opa == WORD_RESET;
      OP_BGTZ:     br_cond = !opa[31] && opa != WORD_RESET;
      OP_BLTZ:     br_cond = opa[31];
      OP_BGEZ:     br_cond = !opa[31];
      OP_JUMP_REG: br_cond = 1'b1;
      default:     br_cond = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flow <= {1'b0, PC_RESET};
    end else begin
      flow.taken <= ex_go && br_cond;
      if (ex_go) begin
        if (!br_cond) flow.next_pc <= seq_pc; // [RL4]
        else if (ex.op == OP_JUMP_REG) flow.next_pc <= opa;
        else flow.next_pc <= seq_pc + (ex.imm << BRANCH_SHIFT); // [RL4]
      end
    end
  end

  // Store aligner and memory request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req <= '0;
    end else begin
      mem_req.valid <= ex_go && (ex.op == OP_LOAD || ex.op == OP_STORE); // [RL3]
      mem_req.write <= ex.op == OP_STORE;
      mem_req.addr  <= data_addr; // [RL4]
      case (ex.size)
        SIZE_BYTE: begin
          mem_req.wdata   <= {4{regb[7:0]}}; // [RL3]
          mem_req.byte_en <= 4'h1 << data_addr[1:0];
        end
        SIZE_HALF: begin
          mem_req.wdata   <= {2{regb[15:0]}};
          mem_req.byte_en <= data_addr[1] ? 4'hC : 4'h3;
        end
        default: begin
          mem_req.wdata   <= regb;
          mem_req.byte_en <= 4'hF;
        end
      endcase
    end
  end

endmodule // iemd_exec_unit

// ===== pkg/iemd_pkg.sv
// Shared types and constants of the integer execute and product/quotient unit.
// Assumes a single core clock; all numbers below are used by name only.
package iemd_pkg;

  typedef logic [31:0] iemd_word_t;
  typedef logic [4:0]  iemd_ridx_t;

  localparam iemd_ridx_t ZERO_REG   = 5'h00;
  localparam iemd_word_t WORD_RESET = 32'h0000_0000;
  // Value of the next-instruction address after reset; arbitrary
  localparam iemd_word_t PC_RESET   = 32'h0000_0000;
  localparam iemd_word_t PC_STEP    = 32'h0000_0004;
  localparam int unsigned BRANCH_SHIFT = 2;

  // Quotient iterations skipped by dividend width
  localparam logic [5:0] SKIP_8     = 6'h17;
  localparam logic [5:0] SKIP_16    = 6'h0F;
  localparam logic [5:0] SKIP_24    = 6'h07;
  localparam logic [5:0] SKIP_32    = 6'h00;
  localparam logic [5:0] DIV_BITS   = 6'h20;
  // Quotient latency in cycles by dividend width; repeat rate is the same
  localparam logic [5:0] DIV_LAT_8  = 6'h0C;
  localparam logic [5:0] DIV_LAT_16 = 6'h13;
  localparam logic [5:0] DIV_LAT_24 = 6'h1A;
  localparam logic [5:0] DIV_LAT_32 = 6'h21;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_NOR, OP_SLT,
    OP_SLL, OP_SRL, OP_SRA, OP_COUNT_LEADING_ZEROS, OP_COUNT_LEADING_ONES,
    OP_LOAD, OP_STORE,
    OP_BEQ, OP_BNE, OP_BLEZ, OP_BGTZ, OP_BLTZ, OP_BGEZ, OP_JUMP_REG,
    OP_PRODUCT_TO_PAIR, OP_PRODUCT_ACCUMULATE, OP_PRODUCT_DEDUCT, OP_PRODUCT_TO_REG,
    OP_QUOTIENT, OP_MOVE_FROM_UPPER, OP_MOVE_FROM_BOTTOM
  } iemd_op_t;

  typedef enum logic [1:0] {
    SIZE_BYTE, SIZE_HALF, SIZE_WORD
  } iemd_size_t;

  typedef struct packed {
    logic       valid;
    iemd_op_t   op;
    logic       unsigned_op;
    logic       use_imm;
    iemd_ridx_t source_a;
    iemd_ridx_t source_b;
    iemd_ridx_t dst;
    iemd_word_t imm;
    iemd_word_t pc;
    iemd_size_t size;
  } iemd_issue_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    iemd_word_t addr;
    iemd_word_t wdata;
    logic [3:0] byte_en;
  } iemd_mem_req_t;

  typedef struct packed {
    logic       taken;
    iemd_word_t next_pc;
  } iemd_flow_t;

  typedef struct packed {
    logic       valid;
    iemd_ridx_t idx;
    iemd_word_t data;
  } iemd_wb_t;

endpackage

// ===== verilog/iemd_regfile.sv
// General register file: thirty-two words, two registered read ports, one write port.
// Read data appear one clock after the address; a same-edge write is not seen.
`timescale 1ns/1ns
module iemd_regfile (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire iemd_pkg::iemd_ridx_t raddr_a,
  input  wire iemd_pkg::iemd_ridx_t raddr_b,
  output iemd_pkg::iemd_word_t   rdata_a,
  output iemd_pkg::iemd_word_t   rdata_b,
  input  wire logic              we,
  input  wire iemd_pkg::iemd_ridx_t waddr,
  input  wire iemd_pkg::iemd_word_t wdata
);
  import iemd_pkg::*;

  iemd_word_t mem [32];

  // Register zero is never stored
  always_ff @(posedge core_clk) begin
    if (we && waddr != ZERO_REG) begin
      mem[waddr] <= wdata; // [RL1] [RL18]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_a <= WORD_RESET;
      rdata_b <= WORD_RESET;
    end else begin
      rdata_a <= (raddr_a == ZERO_REG) ? WORD_RESET : mem[raddr_a]; // [RL1] [RL18]
      rdata_b <= (raddr_b == ZERO_REG) ? WORD_RESET : mem[raddr_b];
    end
  end

endmodule // iemd_regfile

// ===== verif/iemd_exec_properties.sv
// Port checker of the execute unit, bound to its top module.
// Assumes the single core clock; sees the top module's ports only.
`timescale 1ns/1ns
module iemd_exec_properties (
  input wire logic                    core_clk,
  input wire logic                    rst_n,
  input wire iemd_pkg::iemd_issue_t   issue,
  input wire iemd_pkg::iemd_word_t    load_data,
  input wire logic                    stall,
  input wire iemd_pkg::iemd_mem_req_t mem_req,
  input wire iemd_pkg::iemd_flow_t    flow,
  input wire iemd_pkg::iemd_wb_t      wb,
  input wire logic                    pq_busy
);
  import iemd_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic tk, za, dn;
  assign tk = issue.valid && !stall;
  // Register zero as a source makes results known without a model
  assign za = issue.source_a == ZERO_REG;
  assign dn = issue.dst != ZERO_REG;
  property p_wb_zero; wb.valid |-> wb.idx != ZERO_REG; endproperty
  a_wb_zero: assert property (p_wb_zero) else $error("echo of r0");
  property p_add; tk && issue.op == OP_ADD && issue.use_imm && za && dn |-> ##2
    wb.valid && wb.idx == $past(issue.dst, 2) && wb.data == $past(issue.imm, 2); endproperty
  a_add: assert property (p_add) else $error("bad add");
  property p_lz; tk && issue.op == OP_COUNT_LEADING_ZEROS && za && dn |-> ##2
    wb.valid && wb.data == 32'h20; endproperty
  a_lz: assert property (p_lz) else $error("bad zero count");
  property p_l1; tk && issue.op == OP_COUNT_LEADING_ONES && za && dn |-> ##2
    wb.valid && wb.data == 32'h0; endproperty
  a_l1: assert property (p_l1) else $error("bad ones count");
  property p_ld; tk && issue.op == OP_LOAD |-> ##2 mem_req.valid && !mem_req.write; endproperty
  a_ld: assert property (p_ld) else $error("no load");
  property p_st; tk && issue.op == OP_STORE && za |-> ##2
    mem_req.valid && mem_req.write && mem_req.addr == $past(issue.imm, 2); endproperty
  a_st: assert property (p_st) else $error("bad store");
  property p_beq; tk && issue.op == OP_BEQ && za && issue.source_b == ZERO_REG |-> ##2
    flow.taken; endproperty
  a_beq: assert property (p_beq) else $error("branch not taken");
  property p_div; tk && issue.op == OP_QUOTIENT |-> ##2 pq_busy [*8]; endproperty
  a_div: assert property (p_div) else $error("divide too short");
  property p_div_end; tk && issue.op == OP_QUOTIENT |-> ##[10:34] !pq_busy; endproperty
  a_div_end: assert property (p_div_end) else $error("divide too long");
  c_div: cover property (tk && issue.op == OP_QUOTIENT);
  c_deduct: cover property (tk && issue.op == OP_PRODUCT_DEDUCT);
  c_load: cover property (mem_req.valid && !mem_req.write);
endmodule // iemd_exec_properties

bind iemd_exec_unit iemd_exec_properties iemd_exec_properties_i (.core_clk, .rst_n, .issue,
  .load_data, .stall, .mem_req, .flow, .wb, .pq_busy);

// ===== verif/iemd_mem_model.sv
// Data memory on the far side of the load/store port.
// Answers in the request cycle and one more; else a toggling pattern.
`timescale 1ns/1ns
module iemd_mem_model (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire iemd_pkg::iemd_mem_req_t mem_req,
  output iemd_pkg::iemd_word_t         load_data
);
  import iemd_pkg::*;
  iemd_word_t mem [16];
  iemd_word_t held;
  logic       rd;
  assign rd = mem_req.valid && !mem_req.write;
  assign load_data = rd ? mem[mem_req.addr[5:2]] : held;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 32'hA5A5_5A5A;
    end else begin
      held <= rd ? mem[mem_req.addr[5:2]] : ~held;
    end
  end
  // Byte lanes honoured so a stray enable shows up on the next load
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (mem_req.valid && mem_req.write && mem_req.byte_en[i]) begin
        mem[mem_req.addr[5:2]][8*i +: 8] <= mem_req.wdata[8*i +: 8];
      end
    end
  end
endmodule // iemd_mem_model

// ===== verif/iemd_exec_unit_test.sv
// Self-checking bench of the execute unit as issuer.
// Memory model answers loads; random data from a fixed seed.
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module iemd_exec_unit_test;
  import iemd_pkg::*;
  logic          core_clk;
  logic          rst_n;
  iemd_issue_t   issue;
  iemd_word_t    load_data;
  logic          stall;
  iemd_mem_req_t mem_req;
  iemd_flow_t    flow;
  iemd_wb_t      wb;
  logic          pq_busy;
  int            n_mismatch;
  int            comparisons;
  logic [31:0]   seed = 32'h6260497B;
  iemd_word_t    a, b, c;
  logic [63:0]   p;
  time           t0, t1;
  iemd_op_t      ops [6] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_NOR};
  iemd_word_t    divs [4] = '{32'h64, 32'h1234, 32'h12_3456, 32'h1234_5678};
  logic [5:0]    lat [4] = '{DIV_LAT_8, DIV_LAT_16, DIV_LAT_24, DIV_LAT_32};
  iemd_exec_unit iemd_exec_unit_i (.core_clk, .rst_n, .issue, .load_data, .stall, .mem_req,
    .flow, .wb, .pq_busy);
  iemd_mem_model iemd_mem_model_i (.core_clk, .rst_n, .mem_req, .load_data);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic iemd_word_t alu(iemd_op_t op, iemd_word_t x, iemd_word_t y);
    case (op)
      OP_SUB: return x - y;
      OP_AND: return x & y;
      OP_OR: return x | y;
      OP_XOR: return x ^ y;
      OP_NOR: return ~(x | y);
      default: return x + y;
    endcase
  endfunction
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Call at a rising edge; returns at the edge that takes it
  task automatic put(iemd_op_t op, iemd_ridx_t sa, iemd_ridx_t sb, iemd_ridx_t d,
                     iemd_word_t imm, logic ui, logic uo, output time tk);
    int n;
    issue <= '{1'b1, op, uo, ui, sa, sb, d, imm, 32'h100, SIZE_WORD};
    for (n = 0; n < 60; n++) begin
      @(negedge core_clk);
      if (stall === 1'b0) break; // Held while stalled
      @(posedge core_clk);
    end
    if (n == 60) begin
      n_mismatch++;
      summarize();
    end
    @(posedge core_clk);
    tk = $time;
  endtask
  task automatic expect_wb(iemd_ridx_t d, iemd_word_t e);
    int n;
    issue.valid <= 1'b0;
    for (n = 0; n < 60; n++) begin
      @(negedge core_clk);
      if (wb.valid === 1'b1 && wb.idx === d) break;
    end
    if (n == 60) begin
      n_mismatch++;
      summarize();
    end
    `CHK(wb.data, e)
    @(posedge core_clk);
  endtask
  task automatic set_reg(iemd_ridx_t d, iemd_word_t v);
    time t;
    put(OP_ADD, ZERO_REG, ZERO_REG, d, v, 1'b1, 1'b0, t);
    expect_wb(d, v);
  endtask
  initial begin
    issue = '0;
    rst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    put(OP_ADD, 5'h00, 5'h00, 5'h00, 32'hFF, 1'b1, 1'b0, t0);
    put(OP_ADD, 5'h00, 5'h00, 5'h05, 32'h0, 1'b1, 1'b0, t0);
    expect_wb(5'h05, 32'h0);
    $display("zero done");
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 32'hFFFF_FFFF : rnd();
      b = rnd();
      set_reg(5'h01, a);
      set_reg(5'h02, b);
      put(ops[i % 6], 5'h01, 5'h02, 5'h03, 32'h0, 1'b0, 1'b0, t0);
      put(ops[(i + 1) % 6], 5'h03, 5'h01, 5'h04, 32'h0, 1'b0, 1'b0, t0);
      expect_wb(5'h03, alu(ops[i % 6], a, b));
      expect_wb(5'h04, alu(ops[(i + 1) % 6], alu(ops[i % 6], a, b), a));
    end
    $display("alu done");
    for (int k = 0; k < 32; k += 7) begin
      set_reg(5'h01, 32'hFFFF_FFFF >> k);
      set_reg(5'h02, ~(32'hFFFF_FFFF >> k));
      put(OP_COUNT_LEADING_ZEROS, 5'h01, 5'h00, 5'h03, 32'h0, 1'b0, 1'b0, t0);
      put(OP_COUNT_LEADING_ONES, 5'h02, 5'h00, 5'h04, 32'h0, 1'b0, 1'b0, t0);
      expect_wb(5'h03, k);
      expect_wb(5'h04, k);
      put(OP_COUNT_LEADING_ZEROS, 5'h00, 5'h00, 5'h05, 32'h0, 1'b0, 1'b0, t0);
      put(OP_COUNT_LEADING_ONES, 5'h00, 5'h00, 5'h06, 32'h0, 1'b0, 1'b0, t0);
    end
    $display("count done");
    a = rnd();
    set_reg(5'h02, a);
    put(OP_STORE, 5'h00, 5'h02, 5'h00, 32'h10, 1'b0, 1'b0, t0);
    put(OP_LOAD, 5'h00, 5'h00, 5'h07, 32'h10, 1'b0, 1'b0, t0);
    put(OP_BEQ, 5'h00, 5'h00, 5'h00, 32'h4, 1'b0, 1'b0, t0);
    expect_wb(5'h07, a);
    $display("memory done");
    a = rnd();
    b = rnd() & 32'h7FFF;
    c = rnd() | 32'h8000_0000;
    set_reg(5'h01, a);
    set_reg(5'h02, b);
    set_reg(5'h03, c);
    put(OP_PRODUCT_TO_PAIR, 5'h01, 5'h02, 5'h00, 32'h0, 1'b0, 1'b1, t0);
    put(OP_PRODUCT_ACCUMULATE, 5'h01, 5'h03, 5'h00, 32'h0, 1'b0, 1'b1, t1);
    `CHK(t1 - t0, 64'd10)
    put(OP_PRODUCT_DEDUCT, 5'h01, 5'h02, 5'h00, 32'h0, 1'b0, 1'b1, t0);
    `CHK(t0 - t1, 64'd10)
    put(OP_MOVE_FROM_BOTTOM, 5'h00, 5'h00, 5'h05, 32'h0, 1'b0, 1'b1, t1);
    `CHK(t1 - t0, 64'd20)
    put(OP_MOVE_FROM_UPPER, 5'h00, 5'h00, 5'h06, 32'h0, 1'b0, 1'b1, t0);
    p = {32'h0, a} * {32'h0, c};
    expect_wb(5'h05, p[31:0]);
    expect_wb(5'h06, p[63:32]);
    put(OP_PRODUCT_TO_REG, 5'h01, 5'h02, 5'h07, 32'h0, 1'b0, 1'b1, t0);
    expect_wb(5'h07, a * b);
    $display("multiply done");
    for (int i = 0; i < 4; i++) begin
      a = divs[i];
      b = (rnd() & 32'hFF) | 32'h1;
      set_reg(5'h01, a);
      set_reg(5'h02, b);
      put(OP_QUOTIENT, 5'h01, 5'h02, 5'h00, 32'h0, 1'b0, 1'b0, t0);
      put(OP_MOVE_FROM_BOTTOM, 5'h00, 5'h00, 5'h05, 32'h0, 1'b0, 1'b0, t1);
      put(OP_MOVE_FROM_UPPER, 5'h00, 5'h00, 5'h06, 32'h0, 1'b0, 1'b0, t1);
      `CHK(t1 - t0, 64'd10 * lat[i] + 64'd10)
      expect_wb(5'h05, a / b);
      expect_wb(5'h06, a % b);
    end
    $display("divide done");
    summarize();
  end
endmodule // iemd_exec_unit_test
